// [src/wstore_pkg.sv]
// constants for the waveform store refresh control block
package wstore_pkg;
    localparam int          CLK_MHZ       = 20;
    localparam int          PHASE_NS      = 110;
    localparam int          PHASE_CYC_RAW = (PHASE_NS * CLK_MHZ) / 1000;
    localparam int          PHASE_CYC     = (PHASE_CYC_RAW < 1) ? 1 : PHASE_CYC_RAW;
    localparam int          STORE_PERIOD_NS = 550;
    localparam int          ADDR_W        = 10;
    localparam int          DATA_W        = 8;
    localparam int          DEPTH         = 1024;
    localparam int          DIV_W         = 19;
    localparam int          SEL_W         = 5;
    localparam logic [4:0]  SEL_MAX       = 5'h11;
    localparam logic [4:0]  INTERLACE_SEL = 5'h03;
    localparam logic [9:0]  ADDR_ZERO     = 10'h000;
    localparam logic [9:0]  ADDR_FULL     = 10'h3FF;
    localparam logic [7:0]  DATA_ZERO     = 8'h00;
    localparam logic [18:0] DIV_ZERO      = 19'h00000;

    // one-hot rotation of the five phase pulses
    typedef enum logic [4:0] {
        PH1 = 5'h01,
        PH2 = 5'h02,
        PH3 = 5'h04,
        PH4 = 5'h08,
        PH5 = 5'h10
    } phase_t;
endpackage

// [src/waveform_store_refresh_control.sv]
// waveform store control for refreshed mode: phases, divider, counters and store
`timescale 1ns/1ps

// What this block does
// - divider ratio 1,2,4 steps, 1:1 to 1:400000
// - divider pulses pass only while enter-data high
// - 1024x8 store with in, out, address latches
// - read cycles latch addressed word into output
// - read counter scans all 1024 addresses, stepping on every read cycle
// - reading never alters stored contents
// - read counter final stage starts each sweep
// - trigger sets enter-data high when armed
// - gated pulse increments write address, writes sample
// - read regains address lines next cycle, except at 1:1 where writes follow back to back
// - writes continue until counter wraps to zero
// - write MSB falling means full, drops enter-data
// - released mode rearms for next trigger
// - five rotating phase pulses, 100 ns each
// - hold request locks at full, rearm allows one
// - slow ranges reserve alternate cycles for reads
// - write holds direction low phase two to four
module waveform_store_refresh_control (
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic [4:0] range_sel_in,
    input  wire logic       trigger_in,
    input  wire logic       hold_req_in,
    input  wire logic       rearm_in,
    input  wire logic [7:0] sample_in,
    output logic            first_phase_pulse_out,
    output logic            second_phase_pulse_out,
    output logic            fourth_phase_pulse_out,
    output logic            fifth_phase_pulse_out,
    output logic [9:0]      store_addr_out,
    output logic            store_rw_out,
    output logic [7:0]      data_out,
    output logic            enter_data_out,
    output logic            sweep_start_out,
    output logic [9:0]      write_addr_out
);
    // ***************************************************************
    // helpers
    // ***************************************************************
    function automatic logic [18:0] range_ratio(input logic [4:0] sel);
        logic [4:0]  s;
        logic [18:0] r;
        s = (sel > wstore_pkg::SEL_MAX) ? wstore_pkg::SEL_MAX : sel;
        r = (s % 5'h03 == 5'h00) ? 19'h00001 : (s % 5'h03 == 5'h01) ? 19'h00002 : 19'h00004;
        for (int i = 0; i < 6; i++) begin
            if (5'(i) < s / 5'h03) begin
                r = 19'(r * 19'h0000A);
            end
        end
        return r;
    endfunction

    // ***************************************************************
    // input synchronisers
    // ***************************************************************
    logic [15:0] sync1_r;
    logic [15:0] sync2_r;
    logic        trig_d_r;
    logic        rearm_d_r;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync1_r   <= 16'h0000;
            sync2_r   <= 16'h0000;
            trig_d_r  <= 1'b0;
            rearm_d_r <= 1'b0;
        end else begin
            sync1_r   <= {range_sel_in, rearm_in, hold_req_in, trigger_in, sample_in};
            sync2_r   <= sync1_r;
            trig_d_r  <= sync2_r[8];
            rearm_d_r <= sync2_r[10];
        end
    end
    logic trig_edge;
    logic rearm_edge;
    logic hold_req;
    assign trig_edge  = sync2_r[8] && !trig_d_r;
    assign rearm_edge = sync2_r[10] && !rearm_d_r;
    assign hold_req   = sync2_r[9];

    // ***************************************************************
    // phase generator
    // ***************************************************************
    wstore_pkg::phase_t phase_r, phase_nxt;
    logic [7:0]         pcnt_r, pcnt_nxt;
    logic               step;
    logic               cyc_start;
    always_comb begin
        step      = (pcnt_r == 8'(wstore_pkg::PHASE_CYC - 1));
        pcnt_nxt  = step ? 8'h00 : 8'(pcnt_r + 8'h01);
        phase_nxt = phase_r;
        if (step) begin
            case (phase_r)
                wstore_pkg::PH1: phase_nxt = wstore_pkg::PH2;
                wstore_pkg::PH2: phase_nxt = wstore_pkg::PH3;
                wstore_pkg::PH3: phase_nxt = wstore_pkg::PH4;
                wstore_pkg::PH4: phase_nxt = wstore_pkg::PH5;
                wstore_pkg::PH5: phase_nxt = wstore_pkg::PH1;
                default:         phase_nxt = wstore_pkg::PH1;
            endcase
        end
        cyc_start = step && (phase_r == wstore_pkg::PH5);
    end
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            phase_r <= wstore_pkg::PH1;
            pcnt_r  <= 8'h00;
        end else begin
            phase_r <= phase_nxt;
            pcnt_r  <= pcnt_nxt;
        end
    end
    assign first_phase_pulse_out  = (phase_r == wstore_pkg::PH1);
    assign second_phase_pulse_out = (phase_r == wstore_pkg::PH2);
    assign fourth_phase_pulse_out = (phase_r == wstore_pkg::PH4);
    assign fifth_phase_pulse_out  = (phase_r == wstore_pkg::PH5);

    // ***************************************************************
    // divider, control and counters
    // ***************************************************************
    logic [18:0] div_r, div_nxt;
    logic        wreq_r, wreq_nxt;
    logic        slot_r, slot_nxt;
    logic        enter_r, enter_nxt;
    logic        locked_r, locked_nxt;
    logic        once_r, once_nxt;
    logic [9:0]  wr_addr_r, wr_addr_nxt;
    logic [9:0]  rd_addr_r, rd_addr_nxt;
    logic [9:0]  addr_r, addr_nxt;
    logic        wcyc_r, wcyc_nxt;
    logic        rw_r, rw_nxt;
    logic [7:0]  din_r, din_nxt;
    logic [7:0]  dout_r, dout_nxt;
    logic        sweep_r, sweep_nxt;
    logic        div_pulse;
    logic        wr_go;
    logic        trig_go;
    logic        full;
    logic        mem_we;
    logic        filled_r, filled_nxt;
    logic [7:0]  mem [wstore_pkg::DEPTH];

    always_comb begin
        div_nxt     = div_r;
        div_pulse   = 1'b0;
        slot_nxt    = slot_r;
        wr_addr_nxt = wr_addr_r;
        rd_addr_nxt = rd_addr_r;
        addr_nxt    = addr_r;
        wcyc_nxt    = wcyc_r;
        din_nxt     = din_r;
        dout_nxt    = dout_r;
        sweep_nxt   = 1'b0;
        locked_nxt  = locked_r;
        once_nxt    = once_r || rearm_edge;
        wr_go       = 1'b0;
        if (cyc_start) begin
            if (div_r >= 19'(range_ratio(sync2_r[15:11]) - 19'h00001)) begin
                div_nxt   = wstore_pkg::DIV_ZERO;
                div_pulse = 1'b1;
            end else begin
                div_nxt = 19'(div_r + 19'h00001);
            end
            slot_nxt = !slot_r;
        end
        wreq_nxt = enter_r && (wreq_r || div_pulse);
        if (cyc_start) begin
            // slow ranges may write only on odd slots
            wr_go = enter_r && (wreq_r || div_pulse)
                    && (sync2_r[15:11] < wstore_pkg::INTERLACE_SEL || slot_r);
            din_nxt  = sync2_r[7:0];
            dout_nxt = wcyc_r ? dout_r : mem[addr_r];
            if (wr_go) begin
                wr_addr_nxt = 10'(wr_addr_r + 10'h001);
                addr_nxt    = wr_addr_nxt;
                wcyc_nxt    = 1'b1;
                wreq_nxt    = 1'b0;
            end else begin
                rd_addr_nxt = 10'(rd_addr_r + 10'h001);
                addr_nxt    = rd_addr_nxt;
                wcyc_nxt    = 1'b0;
                sweep_nxt   = rd_addr_r[9] && !rd_addr_nxt[9];
            end
        end
        full    = wr_go && wr_addr_r[9] && !wr_addr_nxt[9];
        filled_nxt = filled_r || full;
        trig_go = trig_edge && !enter_r && (!locked_r || once_r);
        if (trig_go && locked_r) begin
            once_nxt = rearm_edge;
        end
        if (full) begin
            locked_nxt = hold_req;
        end else if (!hold_req) begin
            locked_nxt = 1'b0;
            once_nxt   = 1'b0;
        end
        enter_nxt = trig_go ? 1'b1 : (full ? 1'b0 : enter_r);
        rw_nxt    = !(wcyc_nxt && (phase_nxt == wstore_pkg::PH2 || phase_nxt == wstore_pkg::PH3
                      || phase_nxt == wstore_pkg::PH4));
        mem_we    = wcyc_r && step && (phase_r == wstore_pkg::PH4);
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div_r     <= wstore_pkg::DIV_ZERO;
            wreq_r    <= 1'b0;
            slot_r    <= 1'b0;
            enter_r   <= 1'b0;
            locked_r  <= 1'b0;
            once_r    <= 1'b0;
            wr_addr_r <= wstore_pkg::ADDR_ZERO;
            rd_addr_r <= wstore_pkg::ADDR_ZERO;
            addr_r    <= wstore_pkg::ADDR_ZERO;
            wcyc_r    <= 1'b0;
            rw_r      <= 1'b1;
            din_r     <= wstore_pkg::DATA_ZERO;
            dout_r    <= wstore_pkg::DATA_ZERO;
            sweep_r   <= 1'b0;
            filled_r  <= 1'b0;
        end else begin
            div_r     <= div_nxt;
            wreq_r    <= wreq_nxt;
            slot_r    <= slot_nxt;
            enter_r   <= enter_nxt;
            locked_r  <= locked_nxt;
            once_r    <= once_nxt;
            wr_addr_r <= wr_addr_nxt;
            rd_addr_r <= rd_addr_nxt;
            addr_r    <= addr_nxt;
            wcyc_r    <= wcyc_nxt;
            rw_r      <= rw_nxt;
            din_r     <= din_nxt;
            dout_r    <= dout_nxt;
            sweep_r   <= sweep_nxt;
            filled_r  <= filled_nxt;
        end
    end

    // storage has no reset; only write cycles touch it
    always_ff @(posedge clk_in) begin
        if (mem_we) begin
            mem[addr_r] <= din_r;
        end
    end

    assign store_addr_out  = addr_r;
    assign store_rw_out    = rw_r;
    assign data_out        = dout_r;
    assign enter_data_out  = enter_r;
    assign sweep_start_out = sweep_r;
    assign write_addr_out  = wr_addr_r;

    // ***************************************************************
    // assertions
    // ***************************************************************
    sequence s_p1_width;
        first_phase_pulse_out [*2] ##1 second_phase_pulse_out;
    endsequence
    a_phase_rotation: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(first_phase_pulse_out) |-> s_p1_width)
        else $error("phase pulse width or order wrong");
    a_gate_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !enter_r |=> $stable(wr_addr_r))
        else $error("write counter moved with enter-data low");
    a_write_step: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        wr_go |=> (wr_addr_r == 10'($past(wr_addr_r) + 10'h001)) && (addr_r == wr_addr_r))
        else $error("write address not stepped by one");
    sequence s_write_low;
        !store_rw_out [*6] ##1 store_rw_out;
    endsequence
    a_rw_window: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $fell(store_rw_out) |-> second_phase_pulse_out ##0 s_write_low)
        else $error("direction low window wrong");
    a_read_regain: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (wcyc_r && cyc_start && !wr_go) |=> (addr_r == rd_addr_r) && !wcyc_r)
        else $error("read counter did not regain address");
    a_full_stop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $fell(wr_addr_r[9]) |-> !enter_r && (wr_addr_r == wstore_pkg::ADDR_ZERO))
        else $error("store-full did not drop enter-data");
    a_sweep_start: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $fell(rd_addr_r[9]) |-> sweep_start_out ##1 !sweep_start_out)
        else $error("sweep start missing");
    a_trigger_arm: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        trig_go |=> enter_r ##0 (wr_addr_r == $past(wr_addr_r)))
        else $error("trigger did not set enter-data");
    a_lock_ignore: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (locked_r && !once_r && !enter_r) |=> !enter_r)
        else $error("locked store accepted a trigger");
    a_read_latch: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (cyc_start && !wcyc_r && filled_r) |=> data_out == mem[$past(addr_r)])
        else $error("output latch missed addressed word");
    a_read_slot: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (cyc_start && wcyc_r && sync2_r[15:11] >= wstore_pkg::INTERLACE_SEL) |=> !wcyc_r)
        else $error("write took a reserved read slot");
endmodule

// [dv/waveform_front_end_model.sv]
// converter and trigger source model facing the store control
`timescale 1ns/1ps
module waveform_front_end_model (
    input  wire logic       clk_in,
    input  wire logic       first_phase_pulse_in,
    input  wire logic [7:0] level_in,
    input  wire logic       fire_in,
    output logic [7:0]      sample_out,
    output logic            trigger_out
);
    // ************************************
    // conversion and trigger
    // ************************************
    logic [1:0] hold_cnt;
    initial begin
        sample_out  = 8'h00;
        trigger_out = 1'b0;
        hold_cnt    = 2'h0;
    end
    // sample loaded on both clocks of phase one; trigger stretched to three clocks
    always @(posedge clk_in) begin
        if (first_phase_pulse_in) begin
            sample_out <= level_in;
        end
        if (fire_in) begin
            hold_cnt <= 2'h3;
        end else if (hold_cnt != 2'h0) begin
            hold_cnt <= hold_cnt - 2'h1;
        end
        trigger_out <= fire_in || (hold_cnt > 2'h1);
    end
endmodule

// [dv/waveform_store_refresh_control_test.sv]
// self-checking bench for the waveform store refresh control
`timescale 1ns/1ps
module waveform_store_refresh_control_test;
    logic       clk_in;
    logic       reset_n_in;
    logic       hold_req_in;
    logic       rearm_in;
    logic       fire;
    logic       trigger_in;
    logic [4:0] range_sel_in;
    logic [7:0] level;
    logic [7:0] sample_in;
    logic       ph1;
    logic       ph2;
    logic       ph4;
    logic       ph5;
    logic       store_rw_out;
    logic       enter_data_out;
    logic       sweep_start_out;
    logic [9:0] store_addr_out;
    logic [9:0] write_addr_out;
    logic [9:0] prev;
    logic [7:0] data_out;
    int         err_count;
    int         check_count;
    int         n;
    int         ratio [6] = '{1, 2, 4, 10, 20, 40};

    waveform_front_end_model u_waveform_front_end_model (
        .clk_in(clk_in), .first_phase_pulse_in(ph1), .level_in(level),
        .fire_in(fire), .sample_out(sample_in), .trigger_out(trigger_in));

    waveform_store_refresh_control u_waveform_store_refresh_control (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .range_sel_in(range_sel_in),
        .trigger_in(trigger_in), .hold_req_in(hold_req_in), .rearm_in(rearm_in),
        .sample_in(sample_in), .first_phase_pulse_out(ph1), .second_phase_pulse_out(ph2),
        .fourth_phase_pulse_out(ph4), .fifth_phase_pulse_out(ph5),
        .store_addr_out(store_addr_out), .store_rw_out(store_rw_out), .data_out(data_out),
        .enter_data_out(enter_data_out), .sweep_start_out(sweep_start_out),
        .write_addr_out(write_addr_out));

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // ************************************
    // access and compare tasks
    // ************************************
    task automatic tick(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    task automatic step();
        tick(1);
        n++;
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask
    task automatic chk_word(input string what, input logic [9:0] exp, input logic [9:0] got);
        check_count++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask
    task automatic chk_count(input string what, input int exp, input int got);
        check_count++;
        if (got != exp) begin
            $display("BAD %s expected %0d seen %0d", what, exp, got);
            err_count++;
        end
    endtask
    task automatic do_reset(input logic [4:0] sel);
        @(posedge clk_in);
        reset_n_in   <= 1'b0;
        range_sel_in <= sel;
        hold_req_in  <= 1'b0;
        repeat (10) @(posedge clk_in);
        reset_n_in <= 1'b1;
        tick(3);
    endtask
    task automatic shoot();
        @(posedge clk_in);
        fire <= 1'b1;
        @(posedge clk_in);
        fire <= 1'b0;
        tick(1);
    endtask
    task automatic wait_enter(input logic want, input int limit);
        n = 0;
        while (enter_data_out !== want && n < limit) step();
    endtask
    task automatic next_write();
        prev = write_addr_out;
        n = 0;
        while (write_addr_out === prev && n < 2000) step();
    endtask
    task automatic sweep(input logic [7:0] v);
        @(posedge clk_in);
        level <= v;
        tick(30);
        shoot();
        wait_enter(1'b1, 20);
        chk_bit("enter after trigger", 1'b1, enter_data_out);
        wait_enter(1'b0, 11000);
        chk_bit("enter at full", 1'b0, enter_data_out);
        chk_word("wrapped write addr", 10'h000, write_addr_out);
    endtask
    task automatic scan(input logic [7:0] exp);
        n = 0;
        while (sweep_start_out !== 1'b1 && n < 11000) step();
        n = 0;
        do begin
            step();
            if (n % 3000 == 0) chk_word("read word", {2'h0, exp}, {2'h0, data_out});
        end while (sweep_start_out !== 1'b1 && n < 11000);
        chk_count("sweep period", 10240, n);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ************************************
    // test sequence
    // ************************************
    initial begin
        err_count    = 0;
        check_count  = 0;
        reset_n_in   = 1'b0;
        range_sel_in = 5'h00;
        hold_req_in  = 1'b0;
        rearm_in     = 1'b0;
        fire         = 1'b0;
        level        = 8'h00;
        do_reset(5'h00);
        chk_bit("reset enter", 1'b0, enter_data_out);
        chk_bit("reset direction", 1'b1, store_rw_out);
        n = 0;
        while (ph1 !== 1'b1 && n < 20) step();
        n = 0;
        while (ph1 === 1'b1 && n < 20) step();
        chk_count("phase width", 2, n);
        while (ph1 !== 1'b1 && n < 40) step();
        chk_count("phase period", 10, n);
        tick(2);
        chk_bit("second phase", 1'b1, ph2);
        tick(4);
        chk_bit("fourth phase", 1'b1, ph4);
        tick(2);
        chk_bit("fifth phase", 1'b1, ph5);
        chk_bit("first phase off", 1'b0, ph1);
        for (int r = 0; r < 6; r++) begin
            do_reset(r[4:0]);
            tick(40);
            chk_word("idle write addr", 10'h000, write_addr_out);
            shoot();
            wait_enter(1'b1, 20);
            next_write();
            chk_word("first write addr", 10'h001, write_addr_out);
            chk_word("first store addr", 10'h001, store_addr_out);
            next_write();
            chk_count("write spacing", ratio[r] * 10, n);
            n = 0;
            while (store_rw_out !== 1'b0 && n < 1000) step();
            n = 0;
            while (store_rw_out === 1'b0 && n < 20) step();
            chk_count("write strobe width", 6, n);
        end
        do_reset(5'h00);
        sweep(8'h5A);
        scan(8'h5A);
        sweep(8'hA5);
        @(posedge clk_in);
        hold_req_in <= 1'b1;
        sweep(8'h3C);
        shoot();
        wait_enter(1'b1, 20);
        chk_bit("locked enter", 1'b0, enter_data_out);
        scan(8'h3C);
        @(posedge clk_in);
        rearm_in <= 1'b1;
        @(posedge clk_in);
        rearm_in <= 1'b0;
        tick(4);
        shoot();
        wait_enter(1'b1, 20);
        chk_bit("rearmed enter", 1'b1, enter_data_out);
        tally_and_finish();
    end

    initial begin
        repeat (100000) @(posedge clk_in);
        err_count++;
        tally_and_finish();
    end
endmodule
